// ### logic/ubrg_top.sv
// Purpose: bit rate generator with two-place receive buffer and overrun flag
// Assumes: register port strobes one cycle long, never both at once
// Notes:   read data valid only in the cycle after the read strobe
//
// Design decisions made here: the plain strobed port and the register addresses.

`timescale 1ns/10ps

module ubrg_top (
  // clock, reset, enable
  input  wire logic                  mclk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  ce_i,
  // register port
  input  wire logic [ubrg_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [ubrg_pkg::DATA_W-1:0] reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic [ubrg_pkg::DATA_W-1:0] reg_rdata_o,
  // receiver side
  input  wire ubrg_pkg::ubrg_rx_char_t rx_char_i,
  input  wire logic                  rx_idle_i,
  // outputs
  output logic                       rate_tick_o,
  output logic                       irq_o
);
  import ubrg_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  logic [7:0]     div_low_q;
  logic [7:0]     div_high_q;
  logic [7:0]     ctrl_q;
  logic           ovr_q;
  logic [1:0]     rx_cnt_q;
  logic [7:0]     slot0_q;
  logic [7:0]     slot1_q;
  logic [1:0]     irq_stat_q;
  logic [1:0]     irq_stat_d;
  logic [1:0]     irq_en_q;
  logic [1:0]     irq_en_d;
  logic           irq_q;
  logic [7:0]     rdata_q;
  logic           restart;
  logic           pop;
  logic           rx_try;
  logic           accept;
  logic           ovr_set;
  logic           rx_en;
  ubrg_rate_cfg_t cfg;
  logic [5:0]     pre_term;
  logic [15:0]    divisor;
  logic [15:0]    rate_count;
  logic           tick_w;

  assign reg_rdata_o = rdata_q;
  assign irq_o       = irq_q;
  assign rate_tick_o = tick_w;

  // ****************************************
  // decode
  // ****************************************
  // divisor write restarts the counter
  assign restart = reg_wr_i && (reg_addr_i == ADR_DIV_LOW || reg_addr_i == ADR_DIV_HIGH);
  assign pop     = reg_rd_i && reg_addr_i == ADR_RX_DATA && rx_cnt_q != 2'h0;
  assign rx_en   = ctrl_q[CTRL_RXEN_BIT];

  // mode bits and derived counter setup
  assign cfg.wide_counter_select = ctrl_q[CTRL_WIDE_BIT];
  assign cfg.high_speed_select   = ctrl_q[CTRL_HS_BIT];
  assign cfg.sync_sel            = ctrl_q[CTRL_SYNC_BIT];
  assign pre_term = ubrg_pre_term(cfg);
  assign divisor  = ubrg_divisor(cfg.wide_counter_select, div_high_q, div_low_q);

  // ****************************************
  // bit rate counter
  // ****************************************
  ubrg_rate_cnt u_rate_cnt (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .term_i    (pre_term),
    .div_i     (divisor),
    .restart_i (restart),
    .tick_o    (tick_w),
    .count_o   (rate_count)
  );

  // ****************************************
  // software registers
  // ****************************************
  // divisor pair
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      div_low_q  <= DIV_RST;
      div_high_q <= DIV_RST;
    end else if (ce_i && reg_wr_i) begin
      if (reg_addr_i == ADR_DIV_LOW) begin
        div_low_q <= reg_wdata_i;
      end else if (reg_addr_i == ADR_DIV_HIGH) begin
        div_high_q <= reg_wdata_i;
      end
    end
  end

  // control, 8-bit async after reset
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ctrl_q <= CTRL_RST;
    end else if (ce_i && reg_wr_i && reg_addr_i == ADR_CTRL) begin
      ctrl_q <= {4'h0, reg_wdata_i[3:0]};
    end
  end

  // ****************************************
  // receive buffer and overrun
  // ****************************************
  assign rx_try  = rx_char_i.valid && rx_en && !ovr_q;
  assign accept  = rx_try && (rx_cnt_q != RX_DEPTH || pop);
  assign ovr_set = rx_try && rx_cnt_q == RX_DEPTH && !pop;

  // overrun flag, cleared only by dropping receive enable
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ovr_q <= 1'b0;
    end else if (ce_i) begin
      if (!rx_en) begin
        ovr_q <= 1'b0;
      end else if (ovr_set) begin
        ovr_q <= 1'b1;
      end
    end
  end

  // two places, head in slot0
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rx_cnt_q <= 2'h0;
      slot0_q  <= 8'h00;
      slot1_q  <= 8'h00;
    end else if (ce_i) begin
      if (accept && pop) begin
        if (rx_cnt_q == 2'h1) begin
          slot0_q <= rx_char_i.data;
        end else begin
          slot0_q <= slot1_q;
          slot1_q <= rx_char_i.data;
        end
      end else if (accept) begin
        rx_cnt_q <= rx_cnt_q + 2'h1;
        if (rx_cnt_q == 2'h0) begin
          slot0_q <= rx_char_i.data;
        end else begin
          slot1_q <= rx_char_i.data;
        end
      end else if (pop) begin
        rx_cnt_q <= rx_cnt_q - 2'h1;
        slot0_q  <= slot1_q;
      end
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  // sticky status, set wins over clear
  always_comb begin
    irq_stat_d = irq_stat_q;
    irq_en_d   = irq_en_q;
    if (reg_wr_i && reg_addr_i == ADR_IRQ_CLR) begin
      irq_stat_d = irq_stat_d & ~reg_wdata_i[1:0];
    end
    if (reg_wr_i && reg_addr_i == ADR_IRQ_EN) begin
      irq_en_d = reg_wdata_i[1:0];
    end
    if (accept) begin
      irq_stat_d[IRQ_RX_BIT] = 1'b1;
    end
    if (ovr_set) begin
      irq_stat_d[IRQ_OVR_BIT] = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      irq_stat_q <= IRQ_RST;
      irq_en_q   <= IRQ_RST;
      irq_q      <= 1'b0;
    end else if (ce_i) begin
      irq_stat_q <= irq_stat_d;
      irq_en_q   <= irq_en_d;
      irq_q      <= |(irq_stat_d & irq_en_d);
    end
  end

  // ****************************************
  // read port
  // ****************************************
  // data stand only in the cycle after the strobe
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rdata_q <= 8'h00;
    end else if (ce_i) begin
      if (!reg_rd_i) begin
        rdata_q <= 8'h00;
      end else if (reg_addr_i == ADR_DIV_LOW) begin
        rdata_q <= div_low_q;
      end else if (reg_addr_i == ADR_DIV_HIGH) begin
        rdata_q <= div_high_q;
      end else if (reg_addr_i == ADR_CTRL) begin
        rdata_q <= ctrl_q;
      end else if (reg_addr_i == ADR_STATUS) begin
        rdata_q <= {4'h0, rx_cnt_q == RX_DEPTH, rx_cnt_q != 2'h0, rx_idle_i, ovr_q};  // idle
      end else if (reg_addr_i == ADR_RX_DATA) begin
        rdata_q <= slot0_q;
      end else if (reg_addr_i == ADR_IRQ_STAT) begin
        rdata_q <= {6'h00, irq_stat_q};
      end else if (reg_addr_i == ADR_IRQ_EN) begin
        rdata_q <= {6'h00, irq_en_q};
      end else begin
        rdata_q <= 8'h00;  // write-only clear reads zero
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  AST_NARROW_AFTER_RESET: assert property (@(posedge mclk_i)
    sys_rst_i |=> (!cfg.wide_counter_select && divisor[15:8] == 8'h00))
    else $error("counter not 8-bit after reset");

  AST_HIGH_IGNORED: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !cfg.wide_counter_select |-> (divisor == {8'h00, div_low_q}))
    else $error("high divisor used in 8-bit mode");

  AST_WIDE_USES_PAIR: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    cfg.wide_counter_select |-> (divisor == {div_high_q, div_low_q}))
    else $error("16-bit mode does not use divisor pair");

  AST_SYNC_FACTOR: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    cfg.sync_sel |-> pre_term == PRE_TERM_4)
    else $error("synchronous factor is not 4");

  AST_ASYNC_FACTOR: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !cfg.sync_sel |-> pre_term == (cfg.wide_counter_select
      ? (cfg.high_speed_select ? PRE_TERM_4 : PRE_TERM_16)
      : (cfg.high_speed_select ? PRE_TERM_16 : PRE_TERM_64)))
    else $error("asynchronous factor wrong for mode bits");

  AST_OVERRUN_SET: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (ce_i && rx_char_i.valid && rx_en && rx_cnt_q == RX_DEPTH && !pop)
      |=> (ovr_q && rx_cnt_q == RX_DEPTH && $stable(slot1_q)))
    else $error("third char did not raise overrun");

  AST_NO_EARLY_OVERRUN: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (ce_i && !ovr_q && rx_cnt_q != RX_DEPTH) |=> (!ovr_q && rx_cnt_q <= RX_DEPTH))
    else $error("overrun raised with a free place");

  AST_DIV_WRITE_TICK: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (ce_i && restart) |=> (rate_count == 16'h0000 && !tick_w))
    else $error("divisor write did not restart counter");

  COV_FULL: cover property (@(posedge mclk_i) disable iff (sys_rst_i) rx_cnt_q == RX_DEPTH);
  COV_OVR: cover property (@(posedge mclk_i) disable iff (sys_rst_i) $rose(ovr_q));
  COV_WIDE_TICK: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
    cfg.wide_counter_select && tick_w);

endmodule

// ### logic/ubrg_pkg.sv
// Purpose: shared constants, types and helpers of the bit rate generator block
// Assumes: 8-bit register port, 25 MHz mclk_i
// Notes:   offsets are word indices on the plain register port

package ubrg_pkg;

  // ****************************************
  // clock and register map
  // ****************************************
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned ADDR_W        = 3;
  localparam int unsigned DATA_W        = 8;
  localparam logic [2:0]  ADR_DIV_LOW   = 3'h0;  // rate_divisor_low
  localparam logic [2:0]  ADR_DIV_HIGH  = 3'h1;  // rate_divisor_high
  localparam logic [2:0]  ADR_CTRL      = 3'h2;  // rate_control_register
  localparam logic [2:0]  ADR_STATUS    = 3'h3;  // read only
  localparam logic [2:0]  ADR_RX_DATA   = 3'h4;  // receive_data_register, read pops
  localparam logic [2:0]  ADR_IRQ_STAT  = 3'h5;  // read only, sticky
  localparam logic [2:0]  ADR_IRQ_CLR   = 3'h6;  // write only, one clears
  localparam logic [2:0]  ADR_IRQ_EN    = 3'h7;  // read/write

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int unsigned CTRL_WIDE_BIT = 0;  // wide_counter_select
  localparam int unsigned CTRL_HS_BIT   = 1;  // high_speed_select
  localparam int unsigned CTRL_SYNC_BIT = 2;  // synchronous select
  localparam int unsigned CTRL_RXEN_BIT = 3;  // receive enable
  localparam int unsigned ST_OVR_BIT    = 0;  // receive_overrun_flag
  localparam int unsigned ST_IDLE_BIT   = 1;  // receive_idle_flag
  localparam int unsigned ST_AVAIL_BIT  = 2;  // at least one char held
  localparam int unsigned ST_FULL_BIT   = 3;  // both places held
  localparam int unsigned IRQ_RX_BIT    = 0;  // char stored
  localparam int unsigned IRQ_OVR_BIT   = 1;  // overrun raised
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [7:0]  DIV_RST       = 8'h00;
  localparam logic [1:0]  IRQ_RST       = 2'h0;
  localparam logic [1:0]  RX_DEPTH      = 2'h2;

  // ****************************************
  // prescale terminal counts (factor - 1)
  // ****************************************
  localparam logic [5:0]  PRE_TERM_64   = 6'h3f;
  localparam logic [5:0]  PRE_TERM_16   = 6'h0f;
  localparam logic [5:0]  PRE_TERM_4    = 6'h03;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic sync_sel;
    logic high_speed_select;
    logic wide_counter_select;
  } ubrg_rate_cfg_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } ubrg_rx_char_t;

  // prescale terminal from mode bits
  function automatic logic [5:0] ubrg_pre_term(input ubrg_rate_cfg_t c);
    if (c.sync_sel) begin
      return PRE_TERM_4;
    end else if (c.wide_counter_select && c.high_speed_select) begin
      return PRE_TERM_4;
    end else if (c.wide_counter_select || c.high_speed_select) begin
      return PRE_TERM_16;
    end else begin
      return PRE_TERM_64;
    end
  endfunction

  // divisor seen by the counter
  function automatic logic [15:0] ubrg_divisor(input logic wide, input logic [7:0] hi,
                                               input logic [7:0] lo);
    return wide ? {hi, lo} : {8'h00, lo};
  endfunction

endpackage

// ### logic/ubrg_rate_cnt.sv
// Purpose: free running bit rate counter with mode prescaler
// Assumes: term and divisor come from registers in the parent
// Notes:   one tick every (term+1)*(n+1) enabled cycles

`timescale 1ns/10ps

module ubrg_rate_cnt (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        ce_i,
  // setup
  input  wire logic [5:0]  term_i,
  input  wire logic [15:0] div_i,
  input  wire logic        restart_i,
  // outputs
  output logic             tick_o,
  output logic [15:0]      count_o
);
  import ubrg_pkg::*;

  logic [5:0]  pre_q;
  logic [15:0] cnt_q;
  logic        tick_q;
  logic        pre_wrap;
  logic        cnt_wrap;

  assign pre_wrap = (pre_q >= term_i);
  assign cnt_wrap = (cnt_q >= div_i);
  assign tick_o   = tick_q;
  assign count_o  = cnt_q;

  // prescaler, cleared by a divisor write
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pre_q <= 6'h00;
    end else if (ce_i) begin
      if (restart_i) begin
        pre_q <= 6'h00;
      end else if (pre_wrap) begin
        pre_q <= 6'h00;
      end else begin
        pre_q <= pre_q + 6'h01;
      end
    end
  end

  // divisor counter, runs without stop
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cnt_q <= 16'h0000;
    end else if (ce_i) begin
      if (restart_i) begin
        cnt_q <= 16'h0000;
      end else if (pre_wrap) begin
        cnt_q <= cnt_wrap ? 16'h0000 : cnt_q + 16'h0001;
      end
    end
  end

  // tick pulse on full period
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      tick_q <= 1'b0;
    end else if (ce_i) begin
      tick_q <= !restart_i && pre_wrap && cnt_wrap;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  logic [21:0] gap_q;
  logic        seg_ok_q;
  logic [21:0] expect_w;
  logic [5:0]  term_prev_q;
  logic [15:0] div_prev_q;

  assign expect_w = 22'(({16'h0000, term_i} + 22'h1) * ({6'h00, div_i} + 22'h1));

  // period measure between ticks
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      gap_q       <= 22'h0;
      seg_ok_q    <= 1'b0;
      term_prev_q <= 6'h00;
      div_prev_q  <= 16'h0000;
    end else if (ce_i) begin
      term_prev_q <= term_i;
      div_prev_q  <= div_i;
      gap_q       <= tick_q ? 22'h1 : gap_q + 22'h1;
      if (restart_i || term_i != term_prev_q || div_i != div_prev_q) begin
        seg_ok_q <= 1'b0;
      end else if (tick_q) begin
        seg_ok_q <= 1'b1;
      end
    end
  end

  AST_RATE_PERIOD: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (ce_i && tick_q && seg_ok_q && term_i == term_prev_q && div_i == div_prev_q) |-> gap_q == expect_w)
    else $error("tick period differs from factor times divisor plus one");

  AST_RESTART_CLEARS: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (ce_i && restart_i) |=> (pre_q == 6'h00 && cnt_q == 16'h0000 && !tick_q))
    else $error("divisor write did not clear the counter");

  AST_FREE_RUN: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (ce_i && !restart_i && pre_wrap && !cnt_wrap) |=> (cnt_q == $past(cnt_q) + 16'h0001))
    else $error("counter failed to advance");

  COV_TICK: cover property (@(posedge mclk_i) disable iff (sys_rst_i) tick_q && seg_ok_q);

endmodule

// ### testbench/tb.sv
// Purpose: self-checking bench for the bit rate generator and receive buffer
// Assumes: register port as in the package map, 25 MHz mclk_i
// Notes:   tick counts are taken from the divisor write edge

`timescale 1ns/10ps

module tb;
  import ubrg_pkg::*;

  // ****************************************
  // signals and expected status patterns
  // ****************************************
  localparam logic [7:0] S_OVR  = 8'h01 << ST_OVR_BIT;
  localparam logic [7:0] S_IDLE = 8'h01 << ST_IDLE_BIT;
  localparam logic [7:0] S_AVL  = 8'h01 << ST_AVAIL_BIT;
  localparam logic [7:0] S_FULL = 8'h01 << ST_FULL_BIT;
  localparam logic [7:0] C_RXEN = 8'h01 << CTRL_RXEN_BIT;

  logic                mclk_i;
  logic                sys_rst_i;
  logic                ce_i;
  logic [ADDR_W-1:0]   reg_addr_i;
  logic [DATA_W-1:0]   reg_wdata_i;
  logic                reg_wr_i;
  logic                reg_rd_i;
  logic [DATA_W-1:0]   reg_rdata_o;
  ubrg_rx_char_t       rx_char_i;
  logic                rx_idle_i;
  logic                rate_tick_o;
  logic                irq_o;
  int                  errors;
  int                  compares;
  int                  first;
  int                  per;
  int                  fac;
  int                  nn;
  logic [2:0]          m;

  // ****************************************
  // device and clock
  // ****************************************
  ubrg_top i_dut (
    .mclk_i      (mclk_i),
    .sys_rst_i   (sys_rst_i),
    .ce_i        (ce_i),
    .reg_addr_i  (reg_addr_i),
    .reg_wdata_i (reg_wdata_i),
    .reg_wr_i    (reg_wr_i),
    .reg_rd_i    (reg_rd_i),
    .reg_rdata_o (reg_rdata_o),
    .rx_char_i   (rx_char_i),
    .rx_idle_i   (rx_idle_i),
    .rate_tick_o (rate_tick_o),
    .irq_o       (irq_o)
  );

  // 25 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  // ****************************************
  // tasks
  // ****************************************
  // verdict and end of run
  task automatic wrap_up();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i    <= 1'b0;
  endtask

  // one-cycle read strobe, data taken in the following cycle
  task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i   <= 1'b0;
    @(posedge mclk_i);
    chk(reg_rdata_o, exp);
  endtask

  // one complete received char
  task automatic push(input logic [7:0] d);
    @(posedge mclk_i);
    rx_char_i <= {1'b1, d};
    @(posedge mclk_i);
    rx_char_i <= 9'h000;
  endtask

  // edges until the next tick, bounded
  task automatic meas(output int n);
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (rate_tick_o !== 1'b1 && n < 20000);
    if (n >= 20000) begin
      errors++;
      wrap_up();
    end
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    errors      = 0;
    compares    = 0;
    sys_rst_i   = 1'b1;
    ce_i        = 1'b1;
    reg_addr_i  = 3'h0;
    reg_wdata_i = 8'h00;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    rx_char_i   = 9'h000;
    rx_idle_i   = 1'b1;
    repeat (10) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    // reset values
    rdc(ADR_DIV_LOW, DIV_RST);
    rdc(ADR_DIV_HIGH, DIV_RST);
    rdc(ADR_CTRL, CTRL_RST);
    rdc(ADR_IRQ_STAT, 8'h00);
    rdc(ADR_IRQ_EN, 8'h00);
    rdc(ADR_STATUS, S_IDLE);
    // every mode, restart by a divisor write in mid-count
    for (int i = 0; i < 8; i++) begin
      m   = 3'(i);
      fac = (m[2] || (m[0] && m[1])) ? 4 : ((m[0] || m[1]) ? 16 : 64);
      nn  = m[0] ? 257 : 1;
      wr(ADR_CTRL, {5'h00, m});
      wr(ADR_DIV_HIGH, 8'h01);
      repeat (37) @(posedge mclk_i);
      wr(ADR_DIV_LOW, 8'h01);
      meas(first);
      meas(per);
      chk(first, fac * (nn + 1) + 1);
      chk(per, fac * (nn + 1));
    end
    // two places fill, third char overruns
    wr(ADR_IRQ_EN, 8'h03);
    wr(ADR_CTRL, C_RXEN);
    push(8'ha1);
    push(8'ha2);
    rdc(ADR_STATUS, S_IDLE | S_AVL | S_FULL);
    chk(irq_o, 1'b1);
    push(8'ha3);
    rdc(ADR_STATUS, S_IDLE | S_AVL | S_FULL | S_OVR);
    rdc(ADR_IRQ_STAT, 8'h03);
    push(8'ha4);
    rdc(ADR_RX_DATA, 8'ha1);
    rdc(ADR_RX_DATA, 8'ha2);
    rdc(ADR_STATUS, S_IDLE | S_OVR);
    wr(ADR_CTRL, 8'h00);
    rdc(ADR_STATUS, S_IDLE);
    wr(ADR_CTRL, C_RXEN);
    // interrupt clear and mask
    wr(ADR_IRQ_CLR, 8'h03);
    rdc(ADR_IRQ_STAT, 8'h00);
    chk(irq_o, 1'b0);
    push(8'hb1);
    wr(ADR_IRQ_EN, 8'h00);
    repeat (2) @(posedge mclk_i);
    chk(irq_o, 1'b0);
    wr(ADR_IRQ_EN, 8'h01);
    repeat (2) @(posedge mclk_i);
    chk(irq_o, 1'b1);
    rdc(ADR_IRQ_STAT, 8'h01);
    // pop in the same cycle as a third arrival: no overrun
    push(8'hb2);
    @(posedge mclk_i);
    reg_addr_i <= ADR_RX_DATA;
    reg_rd_i   <= 1'b1;
    rx_char_i  <= {1'b1, 8'hb3};
    @(posedge mclk_i);
    reg_rd_i   <= 1'b0;
    rx_char_i  <= 9'h000;
    @(posedge mclk_i);
    chk(reg_rdata_o, 8'hb1);
    rdc(ADR_STATUS, S_IDLE | S_AVL | S_FULL);
    rdc(ADR_RX_DATA, 8'hb2);
    rdc(ADR_RX_DATA, 8'hb3);
    // read-only and write-only places, upper control bits
    wr(ADR_STATUS, 8'hff);
    rdc(ADR_STATUS, S_IDLE);
    rdc(ADR_IRQ_CLR, 8'h00);
    wr(ADR_CTRL, 8'hff);
    rdc(ADR_CTRL, 8'h0f);
    rx_idle_i <= 1'b0;
    rdc(ADR_STATUS, 8'h00);
    // confirm receive idle before dropping the clock enable
    rx_idle_i <= 1'b1;
    rdc(ADR_STATUS, S_IDLE);
    // write ignored while the clock enable is low
    @(posedge mclk_i);
    ce_i <= 1'b0;
    wr(ADR_DIV_LOW, 8'h55);
    ce_i <= 1'b1;
    rdc(ADR_DIV_LOW, 8'h01);
    // reset in mid-run brings back the 8-bit async defaults
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    chk(irq_o, 1'b0);
    chk(reg_rdata_o, 8'h00);
    rdc(ADR_CTRL, CTRL_RST);
    rdc(ADR_DIV_HIGH, DIV_RST);
    rdc(ADR_IRQ_EN, 8'h00);
    wrap_up();
  end

endmodule
